// ### vdspd_pkg.sv
/*
  Shared constants and types of the vector DSP core datapath.
  Assumes a single core clock and one memory subsystem on the far side.
*/
`default_nettype none
package vdspd_pkg;
  // ==========================================================
  // Sizes and timing.
  localparam int NREG = 32;
  localparam int NUNIT = 8;
  localparam int MPY_SLOTS = 4;
  localparam int OCNT_W = 8;
  localparam logic [8:0] GF_POLY = 9'h11B;
  localparam logic [32:0] RND16 = 33'h000004000;
  localparam logic [9:0] FP_BIAS = 10'h07F;

  // ==========================================================
  // Operations and operand widths.
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_SUB = 5'h02, OP_AND = 5'h03,
    OP_OR = 5'h04, OP_XOR = 5'h05, OP_SHL = 5'h06, OP_SHR = 5'h07,
    OP_ROT90 = 5'h08, OP_ROT270 = 5'h09, OP_CONJ = 5'h0A, OP_ITOF = 5'h0B,
    OP_QUAD_WORD_MULTIPLY = 5'h0C, OP_MPY16 = 5'h0D, OP_DOTP8 = 5'h0E, OP_CMPY16 = 5'h0F,
    OP_CMPYC16 = 5'h10, OP_GMPY8 = 5'h11, OP_FMPYSP = 5'h12, OP_CMATMPY = 5'h13,
    OP_LOAD = 5'h14, OP_STORE = 5'h15, OP_FENCE = 5'h16
  } vdspd_op_e;
  typedef enum logic [1:0] {W32 = 2'h0, W64 = 2'h1, W128 = 2'h2} vdspd_width_e;
  typedef enum logic [1:0] {K_M = 2'h0, K_L = 2'h1, K_S = 2'h2, K_D = 2'h3} vdspd_kind_e;

  // ==========================================================
  // Carriers.
  typedef struct packed {
    logic valid;
    vdspd_op_e op;
    vdspd_width_e wd;
    logic [4:0] dst;
    logic [4:0] src1;
    logic [4:0] src2;
  } vdspd_issue_s;
  typedef struct packed {
    logic valid;
    logic side;
    logic [4:0] dst;
    vdspd_width_e wd;
    logic [127:0] data;
  } vdspd_wb_s;
  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic side;
    logic [4:0] dst;
  } vdspd_mreq_s;
  typedef struct packed {
    logic valid;
    logic side;
    logic [4:0] dst;
    logic [31:0] data;
  } vdspd_mrsp_s;
endpackage
`default_nettype wire

// ### vdspd_core.sv
/*
  Execution datapath of the vector DSP core: two register files, eight
  functional units, multiply pipeline and memory fence.
  Assumes the memory subsystem echoes each load with its tag and pulses a
  completion for every request it was given.
*/
`timescale 1ns/10ps
`default_nettype none
// Function
// - Two register files of thirty-two 32-bit registers, sixty-four in all.
// - Packed 8/16-bit, 32, 64-bit operands; multiplies also take 128-bit operands.
// - Wide pair values keep low word in even register, upper in next odd.
// - Quad values start at multiple-of-four register, upper 96 bits in next three.
// - Every one of eight units accepts one instruction each cycle.
// - Multiply units multiply; logic/shift units compute; load/store units move data.
// - SIMD multiplies work on 128-bit vectors, four 32-bit lanes.
// - Multiply unit does lane-parallel 32x32, 16x16, 8x8 dot products per cycle.
// - Galois field multiply on byte lanes of 8-bit and 32-bit data.
// - Complex 16x16 multiplies with rounding.
// - Rounded complex multiply by conjugate of the second operand.
// - One-by-two complex vector times two-by-two matrix; conjugate form reads at most 64 bits, so the second matrix row is zero.
// - Floating-point multiply results follow a fixed multiply latency.
// - Multiply results return after four delay slots, one issue per cycle.
// - One to four single-precision multiplies per instruction.
// - Logic and shift units take up to 64-bit operands.
// - Integer to single conversion on logic and shift units, doubled on wide.
// - Logic unit rotates complex by 90 or 270 degrees; conjugate provided.
// - Fence stalls issue until every outstanding memory transaction completes.
// - After fence completes all earlier writes have reached their endpoints.
module vdspd_core (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire vdspd_pkg::vdspd_issue_s [vdspd_pkg::NUNIT-1:0] ISSUE_I,
  input wire vdspd_pkg::vdspd_mrsp_s [1:0] MEM_RSP_I,
  input wire logic [1:0] MEM_DONE_I,
  output vdspd_pkg::vdspd_mreq_s [1:0] MEM_REQ_O,
  output logic STALL_O,
  output logic [vdspd_pkg::NUNIT-1:0] ILLEGAL_O
);
  import vdspd_pkg::*;

  // ==========================================================
  // State.
  logic [31:0] rf_q [0:1][0:NREG-1];
  vdspd_wb_s [NUNIT-1:0] wb_q;
  vdspd_wb_s [NUNIT-1:0] wb_d;
  vdspd_wb_s [MPY_SLOTS-1:0][1:0] mp_q;
  vdspd_mreq_s [1:0] mreq_d;
  logic [NUNIT-1:0] ill_d;
  logic [OCNT_W-1:0] ocnt_q;
  logic [OCNT_W-1:0] ocnt_d;
  logic fence_q;
  logic fence_req;
  logic fence_nxt;
  vdspd_wb_s [1:0] mpy_in;

  // ==========================================================
  // Helpers.
  function automatic vdspd_kind_e op_kind(input vdspd_op_e op);
    vdspd_kind_e k;
    k = K_L;
    if (op inside {OP_QUAD_WORD_MULTIPLY, OP_MPY16, OP_DOTP8, OP_CMPY16, OP_CMPYC16,
                   OP_GMPY8, OP_FMPYSP, OP_CMATMPY}) begin
      k = K_M;
    end
    if (op inside {OP_LOAD, OP_STORE, OP_FENCE}) begin
      k = K_D;
    end
    return k;
  endfunction

  function automatic logic [127:0] rd(input logic s, input logic [4:0] i, input vdspd_width_e w);
    logic [127:0] r;
    r = '0;
    r[31:0] = rf_q[s][i];
    if (w != W32) begin
      r[63:32] = rf_q[s][i | 5'h01];
    end
    if (w == W128) begin
      r[95:64] = rf_q[s][i | 5'h02];
      r[127:96] = rf_q[s][i | 5'h03];
    end
    return r;
  endfunction

  // Pairs need an even base and quads a base on a multiple of four.
  function automatic logic misaligned(input vdspd_width_e w, input logic [4:0] r);
    logic m;
    m = 1'b0;
    if (w == W64) begin
      m = r[0];
    end
    if (w == W128) begin
      m = (r[1:0] != 2'h0);
    end
    return m;
  endfunction

  function automatic logic [7:0] gf8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] x;
    logic [7:0] p;
    x = {1'b0, a};
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x[7:0];
      end
      x = {x[7:0], 1'b0};
      if (x[8]) begin
        x = x ^ GF_POLY;
      end
    end
    return p;
  endfunction

  function automatic logic [31:0] cm16(input logic [31:0] a, input logic [31:0] b,
                                       input logic ca, input logic cb);
    logic signed [15:0] ar, ai, br, bi;
    logic signed [32:0] re, im;
    ar = a[31:16];
    ai = ca ? -$signed(a[15:0]) : $signed(a[15:0]);
    br = b[31:16];
    bi = cb ? -$signed(b[15:0]) : $signed(b[15:0]);
    re = ar * br - ai * bi + $signed(RND16);
    im = ar * bi + ai * br + $signed(RND16);
    return {re[30:15], im[30:15]};
  endfunction

  function automatic logic [31:0] add2x16(input logic [31:0] a, input logic [31:0] b);
    return {16'(a[31:16] + b[31:16]), 16'(a[15:0] + b[15:0])};
  endfunction

  // Truncating product; denormal inputs flush to zero to keep one cycle.
  // Double and mixed precision multiplies are not built; only single-precision lanes exist.
  function automatic logic [31:0] fmul(input logic [31:0] a, input logic [31:0] b);
    logic [47:0] p;
    logic [9:0] e;
    logic [31:0] r;
    p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    e = {2'h0, a[30:23]} + {2'h0, b[30:23]} - FP_BIAS;
    if (p[47]) begin
      e = e + 10'h001;
      r = {a[31] ^ b[31], e[7:0], p[46:24]};
    end else begin
      r = {a[31] ^ b[31], e[7:0], p[45:23]};
    end
    if (e[9] == 1'b0 && e[8] == 1'b1) begin
      r = {a[31] ^ b[31], 8'hFF, 23'h000000};
    end
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e[9]) begin
      r = {a[31] ^ b[31], 31'h00000000};
    end
    return r;
  endfunction

  function automatic logic [31:0] itof(input logic [31:0] a);
    logic [31:0] m;
    logic [4:0] k;
    m = a[31] ? 32'(-a) : a;
    k = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (m[i]) begin
        k = 5'(i);
      end
    end
    m = m << (5'h1F - k);
    return (a == 32'h00000000) ? 32'h00000000 : {a[31], 8'(8'h7F + k), m[30:8]};
  endfunction

  function automatic logic [127:0] exec(input vdspd_op_e op, input logic [127:0] a,
                                        input logic [127:0] b, input vdspd_width_e w);
    logic [127:0] r;
    r = '0;
    unique case (op)
      OP_ADD, OP_SUB: begin
        for (int j = 0; j < 2; j++) begin
          if (w == W32) begin
            r[64*j +: 32] = (op == OP_ADD) ? 32'(a[64*j +: 32] + b[64*j +: 32])
                                           : 32'(a[64*j +: 32] - b[64*j +: 32]);
          end else begin
            r[64*j +: 64] = (op == OP_ADD) ? 64'(a[64*j +: 64] + b[64*j +: 64])
                                           : 64'(a[64*j +: 64] - b[64*j +: 64]);
          end
        end
      end
      OP_AND: r = a & b;
      OP_OR: r = a | b;
      OP_XOR: r = a ^ b;
      OP_SHL: r[63:0] = a[63:0] << b[5:0];
      OP_SHR: r[63:0] = a[63:0] >> b[5:0];
      OP_ROT90, OP_ROT270, OP_CONJ, OP_ITOF: begin
        for (int j = 0; j < 2; j++) begin
          unique case (op)
            OP_ROT90: r[32*j +: 32] = {16'(-a[32*j +: 16]), a[32*j+16 +: 16]};
            OP_ROT270: r[32*j +: 32] = {a[32*j +: 16], 16'(-a[32*j+16 +: 16])};
            OP_CONJ: r[32*j +: 32] = {a[32*j+16 +: 16], 16'(-a[32*j +: 16])};
            default: r[32*j +: 32] = itof(a[32*j +: 32]);
          endcase
        end
      end
      OP_QUAD_WORD_MULTIPLY, OP_DOTP8, OP_GMPY8, OP_FMPYSP, OP_CMPY16, OP_CMPYC16: begin
        for (int j = 0; j < 4; j++) begin
          unique case (op)
            OP_QUAD_WORD_MULTIPLY: r[32*j +: 32] = 32'(a[32*j +: 32] * b[32*j +: 32]);
            OP_DOTP8: r[32*j +: 32] = 32'(a[32*j +: 8] * b[32*j +: 8] + a[32*j+8 +: 8] * b[32*j+8 +: 8]
                                          + a[32*j+16 +: 8] * b[32*j+16 +: 8] + a[32*j+24 +: 8] * b[32*j+24 +: 8]);
            OP_GMPY8: r[32*j +: 32] = {gf8(a[32*j+24 +: 8], b[32*j+24 +: 8]), gf8(a[32*j+16 +: 8], b[32*j+16 +: 8]),
                                       gf8(a[32*j+8 +: 8], b[32*j+8 +: 8]), gf8(a[32*j +: 8], b[32*j +: 8])};
            OP_FMPYSP: r[32*j +: 32] = fmul(a[32*j +: 32], b[32*j +: 32]);
            OP_CMPY16: r[32*j +: 32] = cm16(a[32*j +: 32], b[32*j +: 32], 1'b0, 1'b0);
            default: r[32*j +: 32] = cm16(a[32*j +: 32], b[32*j +: 32], 1'b0, 1'b1);
          endcase
        end
      end
      OP_MPY16: begin
        for (int j = 0; j < 8; j++) begin
          r[16*j +: 16] = 16'(a[16*j +: 16] * b[16*j +: 16]);
        end
      end
      OP_CMATMPY: begin
        // Vector in a[63:0], matrix rows in b; w other than W128 conjugates the vector.
        r[31:0] = add2x16(cm16(a[31:0], b[31:0], w != W128, 1'b0),
                          cm16(a[63:32], b[95:64], w != W128, 1'b0));
        r[63:32] = add2x16(cm16(a[31:0], b[63:32], w != W128, 1'b0),
                           cm16(a[63:32], b[127:96], w != W128, 1'b0));
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Issue, decode and execute.
  always_comb begin
    wb_d = '0;
    mreq_d = '0;
    ill_d = '0;
    fence_req = 1'b0;
    for (int u = 0; u < NUNIT; u++) begin
      logic sd;
      logic bad;
      vdspd_issue_s is;
      vdspd_kind_e k;
      sd = u[2];
      is = ISSUE_I[u];
      k = op_kind(is.op);
      bad = misaligned(is.wd, is.dst) | misaligned(is.wd, is.src1) | misaligned(is.wd, is.src2);
      bad = bad | (is.wd == W128 && k != K_M && is.op != OP_CMATMPY) | (is.wd > W128);
      bad = bad | (k == K_M && u[1:0] != 2'h0) | (k == K_D && u[1:0] != 2'h3);
      bad = bad | (k == K_L && u[1:0] != 2'h1 && u[1:0] != 2'h2);
      bad = bad | (is.op inside {OP_ROT90, OP_ROT270} && u[1:0] != 2'h1);
      if (is.valid && !fence_q && is.op != OP_NOP) begin
        ill_d[u] = bad;
        if (!bad && k == K_D) begin
          if (is.op == OP_FENCE) begin
            fence_req = 1'b1;
          end else begin
            mreq_d[u[2]].valid = 1'b1;
            mreq_d[u[2]].we = (is.op == OP_STORE);
            mreq_d[u[2]].addr = rf_q[sd][is.src1];
            mreq_d[u[2]].wdata = rf_q[sd][is.dst];
            mreq_d[u[2]].side = sd;
            mreq_d[u[2]].dst = is.dst;
          end
        end else if (!bad) begin
          wb_d[u].valid = 1'b1;
          wb_d[u].side = sd;
          wb_d[u].dst = is.dst;
          wb_d[u].wd = is.wd;
          wb_d[u].data = exec(is.op, rd(sd, is.src1, is.wd), rd(sd, is.src2, is.wd), is.wd);
        end
      end
    end
  end

  // Outstanding count: requests issued this cycle minus completions reported.
  // Eight bits of count; more than 255 requests in flight would wrap and free the fence early.
  assign ocnt_d = OCNT_W'(ocnt_q + OCNT_W'(mreq_d[0].valid) + OCNT_W'(mreq_d[1].valid)
                          - OCNT_W'(MEM_DONE_I[0]) - OCNT_W'(MEM_DONE_I[1]));
  assign mpy_in = {wb_d[4], wb_d[0]};
  assign fence_nxt = (fence_q | fence_req) & (ocnt_d != '0 | (fence_req & !fence_q));

  // ==========================================================
  // Pipelines and fence.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wb_q <= '0;
      mp_q <= '0;
      MEM_REQ_O <= '0;
      ILLEGAL_O <= '0;
      ocnt_q <= '0;
      fence_q <= 1'b0;
      STALL_O <= 1'b0;
    end else begin
      wb_q <= wb_d;
      // Multiply results bypass wb_q and retire from the last slot.
      mp_q <= {mp_q[MPY_SLOTS-2:0], mpy_in};
      MEM_REQ_O <= mreq_d;
      ILLEGAL_O <= ill_d;
      ocnt_q <= ocnt_d;
      // Fence drops only once nothing is outstanding, so earlier writes have landed.
      fence_q <= fence_nxt;
      STALL_O <= fence_nxt;
    end
  end

  // ==========================================================
  // Register write-back; on a shared destination higher units win, multiply results beat them, load replies beat all.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      for (int s = 0; s < 2; s++) begin
        for (int i = 0; i < NREG; i++) begin
          rf_q[s][i] <= 32'h00000000;
        end
      end
    end else begin
      for (int u = 0; u < NUNIT + 2; u++) begin
        vdspd_wb_s w;
        w = (u >= NUNIT) ? mp_q[MPY_SLOTS-1][u-NUNIT] : ((u[1:0] == 2'h0) ? '0 : wb_q[u]);
        if (w.valid) begin
          rf_q[w.side][w.dst] <= w.data[31:0];
          if (w.wd != W32) begin
            rf_q[w.side][w.dst | 5'h01] <= w.data[63:32];
          end
          if (w.wd == W128) begin
            rf_q[w.side][w.dst | 5'h02] <= w.data[95:64];
            rf_q[w.side][w.dst | 5'h03] <= w.data[127:96];
          end
        end
      end
      for (int p = 0; p < 2; p++) begin
        if (MEM_RSP_I[p].valid) begin
          rf_q[MEM_RSP_I[p].side][MEM_RSP_I[p].dst] <= MEM_RSP_I[p].data;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### vdspd_core_chk.sv
/*
  Checker for the core: fence stall and refused issues.
  Assumes it is bound to vdspd_core.
*/
`timescale 1ns/10ps
`default_nettype none
module vdspd_core_chk (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire vdspd_pkg::vdspd_issue_s [vdspd_pkg::NUNIT-1:0] ISSUE_I,
  input wire logic [1:0] MEM_DONE_I,
  input wire vdspd_pkg::vdspd_mreq_s [1:0] MEM_REQ_O,
  input wire logic STALL_O,
  input wire logic [vdspd_pkg::NUNIT-1:0] ILLEGAL_O
);
  import vdspd_pkg::*;
  // ==========================================================
  // Outstanding count, kept apart from the core's own.
  logic [NUNIT-1:0] vld;
  logic [OCNT_W-1:0] out_q;
  logic [OCNT_W-1:0] out_d;
  logic fence_in;
  for (genvar k = 0; k < NUNIT; k++) begin : g_vld
    assign vld[k] = ISSUE_I[k].valid;
  end
  assign out_d = out_q + OCNT_W'(MEM_REQ_O[0].valid) + OCNT_W'(MEM_REQ_O[1].valid)
    - OCNT_W'(MEM_DONE_I[0]) - OCNT_W'(MEM_DONE_I[1]);
  assign fence_in = !STALL_O && vld[3] && ISSUE_I[3].op == OP_FENCE && ISSUE_I[3].wd == W32;
  always_ff @(posedge CLK_I) begin
    out_q <= RST_I ? '0 : out_d;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ==========================================================
  // Assertions.
  a_fence_stall: assert property (fence_in |=> STALL_O)
    else $error("fence did not stall");
  a_stall_hold: assert property (STALL_O && out_d != '0 |=> STALL_O)
    else $error("stall dropped early");
  a_stall_release: assert property (STALL_O && out_d == '0 |=> !STALL_O)
    else $error("stall held too long");
  a_stall_ignore: assert property (STALL_O |=> ILLEGAL_O == '0 && !MEM_REQ_O[0].valid && !MEM_REQ_O[1].valid)
    else $error("issue taken while stalled");
  a_illegal_cause: assert property (ILLEGAL_O != '0 |-> (ILLEGAL_O & ~$past(vld)) == '0 && !$past(STALL_O))
    else $error("refusal without issue");
  a_odd_pair: assert property (!STALL_O && vld[1] && ISSUE_I[1].wd == W64 && ISSUE_I[1].dst[0] |=> ILLEGAL_O[1])
    else $error("odd pair accepted");
  a_quad_base: assert property (!STALL_O && vld[0] && ISSUE_I[0].wd == W128 && ISSUE_I[0].dst[1:0] != 2'h0
    |=> ILLEGAL_O[0])
    else $error("unaligned quad accepted");
  a_wide_logic: assert property (!STALL_O && vld[1] && ISSUE_I[1].wd == W128 |=> ILLEGAL_O[1])
    else $error("wide logic op accepted");
  a_rotate_unit: assert property (!STALL_O && vld[2] && ISSUE_I[2].op inside {OP_ROT90, OP_ROT270}
    |=> ILLEGAL_O[2])
    else $error("rotation accepted off logic unit");
  a_store_source: assert property (MEM_REQ_O[0].valid |-> $past(vld[3]) && !$past(STALL_O))
    else $error("request without issue");
endmodule
bind vdspd_core vdspd_core_chk u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .ISSUE_I(ISSUE_I),
  .MEM_DONE_I(MEM_DONE_I), .MEM_REQ_O(MEM_REQ_O), .STALL_O(STALL_O), .ILLEGAL_O(ILLEGAL_O));
`default_nettype wire

// ### vdspd_mem_model.sv
/*
  Memory side model: serves each port in order after a set delay.
  Assumes requests as one-cycle valid pulses from the core.
*/
`timescale 1ns/10ps
`default_nettype none
module vdspd_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] delay_i,
  input wire vdspd_pkg::vdspd_mreq_s [1:0] req_i,
  output var vdspd_pkg::vdspd_mrsp_s [1:0] rsp_o,
  output var logic [1:0] done_o
);
  import vdspd_pkg::*;
  // ==========================================================
  // Unwritten words read as address plus a fixed offset.
  logic [31:0] mem [logic [31:0]];
  vdspd_mreq_s q [2][$];
  int cnt [2];
  vdspd_mreq_s r;
  vdspd_mrsp_s rv;
  logic [1:0] dn;
  always @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      // Idle data flips so a stale word is never mistaken for a reply.
      rv = '{1'b0, 1'b0, 5'h00, rst_i ? 32'h0 : ~rsp_o[p].data};
      dn[p] = 1'b0;
      if (rst_i) begin
        q[p].delete();
        cnt[p] = 0;
      end else begin
        if (req_i[p].valid) begin
          q[p].push_back(req_i[p]);
        end
        if (q[p].size() > 0 && cnt[p] >= int'(delay_i)) begin
          r = q[p].pop_front();
          cnt[p] = 0;
          if (r.we) begin
            mem[r.addr] = r.wdata;
          end else begin
            rv = '{1'b1, r.side, r.dst, mem.exists(r.addr) ? mem[r.addr] : r.addr + 32'h12345678};
          end
          dn[p] = 1'b1;
        end else if (q[p].size() > 0) begin
          cnt[p]++;
        end
      end
      rsp_o[p] <= rv;
    end
    done_o <= dn;
  end
endmodule
`default_nettype wire

// ### vector_dsp_core_datapath_bench.sv
/*
  Bench for the core: register files, parallel issue, refusals, fence.
  Assumes the memory model on the far side and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module vector_dsp_core_datapath_bench;
  import vdspd_pkg::*;
  // ==========================================================
  // Clock, reset and wiring.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] delay = 4'h0;
  vdspd_issue_s [NUNIT-1:0] issue = '0;
  vdspd_issue_s [NUNIT-1:0] bun = '0;
  vdspd_mrsp_s [1:0] mem_rsp;
  logic [1:0] mem_done;
  vdspd_mreq_s [1:0] mem_req;
  logic stall;
  logic [NUNIT-1:0] illegal;
  int err_count = 0;
  int comparisons = 0;
  localparam logic [31:0] PAT = 32'h12345678;
  always #2 clk = ~clk;
  vdspd_core DUT (.CLK_I(clk), .RST_I(rst), .ISSUE_I(issue), .MEM_RSP_I(mem_rsp),
    .MEM_DONE_I(mem_done), .MEM_REQ_O(mem_req), .STALL_O(stall), .ILLEGAL_O(illegal));
  vdspd_mem_model u_mem (.clk_i(clk), .rst_i(rst), .delay_i(delay), .req_i(mem_req),
    .rsp_o(mem_rsp), .done_o(mem_done));
  // ==========================================================
  // Shared tasks.
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic put(input int s, input vdspd_op_e op, input vdspd_width_e wd,
      input logic [4:0] d, input logic [4:0] a, input logic [4:0] b);
    bun[s] = '{1'b1, op, wd, d, a, b};
  endtask
  // The whole bundle is taken at one edge; outputs are read just after it.
  task automatic go();
    @(posedge clk);
    issue <= bun;
    bun = '0;
    @(posedge clk);
    issue <= '0;
    #1;
  endtask
  task automatic store_chk(input int sd, input logic [4:0] rg, input logic [31:0] exp);
    put(3 + 4 * sd, OP_STORE, W32, rg, 5'h00, 5'h00);
    go();
    check({mem_req[sd].valid, mem_req[sd].we, mem_req[sd].wdata}, {2'h3, exp});
  endtask
  // ==========================================================
  // Scenarios.
  task automatic s_load_store();
    put(3, OP_LOAD, W32, 5'h01, 5'h00, 5'h00);
    put(7, OP_LOAD, W32, 5'h02, 5'h00, 5'h00);
    go();
    check({mem_req[0].valid, mem_req[0].we, mem_req[1].valid, mem_req[1].we}, 64'hA);
    repeat (6) @(posedge clk);
    store_chk(0, 5'h01, PAT);
    store_chk(0, 5'h02, 32'h0);
    store_chk(1, 5'h02, PAT);
  endtask
  task automatic s_units();
    put(1, OP_ROT90, W32, 5'h04, 5'h01, 5'h01);
    put(2, OP_SUB, W32, 5'h05, 5'h00, 5'h01);
    put(5, OP_ROT270, W32, 5'h04, 5'h02, 5'h02);
    put(6, OP_ADD, W32, 5'h03, 5'h02, 5'h02);
    go();
    repeat (2) @(posedge clk);
    store_chk(0, 5'h04, {16'h0 - PAT[15:0], PAT[31:16]});
    store_chk(0, 5'h05, 32'h0 - PAT);
    store_chk(1, 5'h04, {PAT[15:0], 16'h0 - PAT[31:16]});
    store_chk(1, 5'h03, PAT + PAT);
  endtask
  task automatic s_illegal();
    int sl[4] = '{1, 0, 1, 2};
    vdspd_op_e op[4] = '{OP_ADD, OP_QUAD_WORD_MULTIPLY, OP_ADD, OP_ROT90};
    vdspd_width_e wd[4] = '{W64, W128, W128, W32};
    logic [4:0] dst[4] = '{5'h01, 5'h02, 5'h04, 5'h00};
    for (int k = 0; k < 4; k++) begin
      put(sl[k], op[k], wd[k], dst[k], 5'h00, 5'h00);
      go();
      check(illegal, 64'(1) << sl[k]);
    end
    store_chk(0, 5'h01, PAT);
  endtask
  task automatic s_mpy();
    put(0, OP_QUAD_WORD_MULTIPLY, W32, 5'h08, 5'h01, 5'h01);
    put(4, OP_GMPY8, W32, 5'h08, 5'h02, 5'h02);
    go();
    repeat (2) @(posedge clk);
    store_chk(0, 5'h08, 32'h00000000);
    store_chk(0, 5'h08, 32'(PAT * PAT));
    store_chk(1, 5'h08, 32'h1F67A49C);
    put(0, OP_CMPY16, W32, 5'h09, 5'h01, 5'h04);
    put(4, OP_DOTP8, W32, 5'h09, 5'h02, 5'h02);
    go();
    repeat (3) @(posedge clk);
    store_chk(0, 5'h09, 32'hE768C82D);
    store_chk(1, 5'h09, 32'h000060F8);
  endtask
  task automatic s_fence();
    logic seen;
    @(posedge clk);
    delay <= 4'h4;
    put(3, OP_FENCE, W32, 5'h00, 5'h00, 5'h00);
    put(7, OP_LOAD, W32, 5'h06, 5'h02, 5'h00);
    go();
    check(stall, 1'b1);
    check({mem_req[1].valid, mem_req[1].we, mem_req[1].side, mem_req[1].dst, mem_req[1].addr}, {3'h5, 5'h06, PAT});
    seen = 1'b0;
    // A refusable issue is held while stalled; it must pass without a flag.
    for (int n = 0; n < 30 && !seen; n++) begin
      seen = mem_done[1];
      @(posedge clk);
      issue[1] <= seen ? '0 : '{1'b1, OP_ADD, W64, 5'h01, 5'h00, 5'h00};
      #1;
      check({stall, illegal}, {!seen, 8'h00});
    end
    if (!seen) begin
      err_count++;
      return;
    end
    put(3, OP_FENCE, W32, 5'h00, 5'h00, 5'h00);
    go();
    check(stall, 1'b1);
    @(posedge clk);
    #1;
    check(stall, 1'b0);
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check({stall, illegal, mem_req[0].valid, mem_req[1].valid}, 64'h0);
    s_load_store();
    s_units();
    s_illegal();
    s_mpy();
    s_fence();
    print_verdict();
  end
endmodule
`default_nettype wire
